// ===== vor_pkg.sv
// vor_pkg: constants and types of the vibration output readout block
package vor_pkg;

    // ********************************************************************
    // register offsets (7-bit byte address carried in each frame)
    // ********************************************************************
    localparam logic [6:0] VOR_ADDR_TEMP = 7'h08;
    localparam logic [6:0] VOR_ADDR_SUPPLY = 7'h0A;
    localparam logic [6:0] VOR_ADDR_IDX_LO = 7'h10;
    localparam logic [6:0] VOR_ADDR_IDX_HI = 7'h11;
    localparam logic [6:0] VOR_ADDR_REC_LO = 7'h12;
    localparam logic [6:0] VOR_ADDR_X = 7'h14;
    localparam logic [6:0] VOR_ADDR_Y = 7'h16;
    localparam logic [6:0] VOR_ADDR_Z = 7'h18;
    localparam logic [6:0] VOR_ADDR_CMD_HI = 7'h3F;

    // ********************************************************************
    // field positions and reset values
    // ********************************************************************
    localparam int VOR_CMD_RETRIEVE_BIT = 5;  // bit 13 of command_word
    localparam int VOR_CMD_IDX_CLR_BIT = 2;   // bit 10 of command_word
    localparam int VOR_IDX_HI_BIT = 0;        // bit 8 of sample_index
    localparam int VOR_IDX_W = 9;
    localparam int VOR_REC_W = 4;
    localparam int VOR_NAXIS = 3;
    localparam int VOR_DEPTH = 512;
    localparam int VOR_RESULT_W = 12;
    localparam logic [15:0] VOR_OUT_RST = 16'h8000;
    localparam logic [8:0] VOR_IDX_RST = 9'h000;
    localparam logic [3:0] VOR_REC_RST = 4'h0;

    // ********************************************************************
    // timing of the supply and temperature measurements
    // ********************************************************************
    localparam int VOR_CLK_HZ = 25_000_000;
    localparam int VOR_SUP_WIN_US = 5120;
    localparam int VOR_TEMP_WIN_US = 1700;
    localparam int VOR_SUP_WIN_CYC = VOR_CLK_HZ / 1_000_000 * VOR_SUP_WIN_US;
    localparam int VOR_TEMP_WIN_CYC =
        VOR_CLK_HZ / 1_000_000 * VOR_TEMP_WIN_US;
    localparam int VOR_SUP_NSAMP = 256;    // 50 kHz over the window
    localparam int VOR_TEMP_NSAMP = 64;
    localparam int VOR_SUP_SHIFT = 8;
    localparam int VOR_TEMP_SHIFT = 6;

    // ********************************************************************
    // types
    // ********************************************************************
    typedef enum logic {VOR_MEAS_IDLE, VOR_MEAS_RUN} vor_meas_e;
    typedef logic [VOR_NAXIS-1:0][15:0] vor_trio_t;

    // one serial frame: write flag, address, data byte
    typedef struct packed {
        logic wr;
        logic [6:0] addr;
        logic [7:0] data;
    } vor_frame_s;

    // one sample set written by the capture or retrieve engine
    typedef struct packed {
        logic wr;
        logic [VOR_IDX_W-1:0] addr;
        vor_trio_t data;
    } vor_capture_s;

endpackage : vor_pkg

// ===== vor_readout.sv
// vor_readout: serial register access to axis buffers and measurements
//
// Overview of operation
// - record done: index to zero, first sample of each axis presented
// - sample index picks the buffer position shown in all axis registers
// - each axis register read outside real-time mode advances the sample index by one
// - index is nine bits; upper bits unused and read zero
// - record index plus retrieve command loads a stored record
// - axis data encoding follows configured range and recording mode
// - axis registers are 16-bit read-only, binary or twos complement
// - time mode samples are twos complement, 0x8000 to 0x7FFF
// - real-time: axis read selects stream, data-ready times next reads
// - real-time samples use the 20 g time format regardless of range
// - record end: supply sampled at 50 kHz for 5.12 ms, averaged
// - record end: 64 temperature samples over 1.7 ms, averaged
// - in real-time mode measurements refresh only when mode starts
// - supply result is 12-bit unsigned, upper four bits zero
// - temperature result is 12-bit offset binary, upper bits zero
// - time records hold 512 samples, spectral records 256 per axis
// - command bits start their function and clear themselves when done
module vor_readout
    import vor_pkg::*;
#(
    parameter int SUPPLY_WIN_CYC = VOR_SUP_WIN_CYC,
    parameter int TEMP_WIN_CYC = VOR_TEMP_WIN_CYC
) (
    // system clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial port, sclk idles high
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout,
    // capture engine side
    input vor_capture_s cap,
    input wire logic record_done,
    input wire logic realtime_mode,
    input wire logic rt_valid,
    input wire logic [15:0] rt_sample,
    output logic data_ready,
    // stored record engine side
    output logic retrieve_req,
    output logic [VOR_REC_W-1:0] retrieve_record,
    input wire logic retrieve_done,
    // supply and temperature converters
    output logic supply_start,
    input wire logic supply_valid,
    input wire logic [VOR_RESULT_W-1:0] supply_code,
    output logic temp_start,
    input wire logic temp_valid,
    input wire logic [VOR_RESULT_W-1:0] temp_code
);

    // ********************************************************************
    // link side, runs on sclk
    // ********************************************************************
    logic [3:0] bit_cnt_q;
    logic [14:0] rx_sh_q;
    vor_frame_s rx_word_q;
    logic frame_tgl_q;
    logic dout_q;
    logic [14:0] tx_sh_q;
    logic [15:0] resp_q;
    // bit counter, cleared by the frame select so short frames are dropped
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // input shift; a whole word is held and announced by a toggle
    always_ff @(posedge sclk or negedge nrst) begin
        if (!nrst) begin
            rx_sh_q <= 15'h0000;
            rx_word_q <= '0;
            frame_tgl_q <= 1'b0;
        end else begin
            rx_sh_q <= {rx_sh_q[13:0], din};
            if (bit_cnt_q == 4'hF) begin
                rx_word_q <= {rx_sh_q, din};
                frame_tgl_q <= ~frame_tgl_q;
            end
        end
    end

    // output shift on falling edges; resp_q is static between frames
    always_ff @(negedge sclk or negedge nrst) begin
        if (!nrst) begin
            dout_q <= 1'b0;
            tx_sh_q <= 15'h0000;
        end else if (bit_cnt_q == 4'h0) begin
            {dout_q, tx_sh_q} <= resp_q;
        end else begin
            {dout_q, tx_sh_q} <= {tx_sh_q, 1'b0};
        end
    end
    assign dout = dout_q;
    // ********************************************************************
    // frame event crossing into clk
    // ********************************************************************
    logic [2:0] frame_sync_q;
    logic frame_evt;
    logic wr_evt;
    logic rd_evt;
    logic axis_hit;
    logic axis_rd;
    logic [1:0] axis_sel;
    logic idx_clr;
    // toggle synchroniser; stage 0 feeds stage 1 only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frame_sync_q <= 3'h0;
        end else begin
            frame_sync_q <= {frame_sync_q[1:0], frame_tgl_q};
        end
    end

    // decode of the completed frame; rx_word_q is stable after the toggle
    assign frame_evt = frame_sync_q[1] ^ frame_sync_q[2];
    assign wr_evt = frame_evt & rx_word_q.wr;
    assign rd_evt = frame_evt & ~rx_word_q.wr;
    assign axis_hit = (rx_word_q.addr == VOR_ADDR_X) ||
                      (rx_word_q.addr == VOR_ADDR_Y) ||
                      (rx_word_q.addr == VOR_ADDR_Z);
    assign axis_rd = rd_evt & axis_hit;
    assign axis_sel = rx_word_q.addr[2:1] - VOR_ADDR_X[2:1];
    assign idx_clr = wr_evt && (rx_word_q.addr == VOR_ADDR_CMD_HI) &&
                     rx_word_q.data[VOR_CMD_IDX_CLR_BIT];
    // ********************************************************************
    // sample index, record index, retrieve command
    // ********************************************************************
    logic [VOR_IDX_W-1:0] idx_q;
    logic [VOR_REC_W-1:0] rec_q;
    logic retrieve_q;
    logic [VOR_REC_W-1:0] retrieve_rec_q;
    // sample index: cleared on refresh, byte writes, advance on axis read outside real-time mode
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_q <= VOR_IDX_RST;
        end else if (record_done || retrieve_done || idx_clr) begin
            idx_q <= VOR_IDX_RST;
        end else if (wr_evt && rx_word_q.addr == VOR_ADDR_IDX_HI) begin
            idx_q[8] <= rx_word_q.data[VOR_IDX_HI_BIT];
        end else if (wr_evt && rx_word_q.addr == VOR_ADDR_IDX_LO) begin
            idx_q[7:0] <= rx_word_q.data;
        end else if (axis_rd && !realtime_mode) begin
            idx_q <= idx_q + 9'h001;  // wraps at 511
        end
    end

    // record index, low nibble of its low byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rec_q <= VOR_REC_RST;
        end else if (wr_evt && rx_word_q.addr == VOR_ADDR_REC_LO) begin
            rec_q <= rx_word_q.data[VOR_REC_W-1:0];
        end
    end

    // retrieve command: held until the engine is done, the set wins
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            retrieve_q <= 1'b0;
            retrieve_rec_q <= VOR_REC_RST;
        end else if (wr_evt && rx_word_q.addr == VOR_ADDR_CMD_HI &&
                     rx_word_q.data[VOR_CMD_RETRIEVE_BIT]) begin
            retrieve_q <= 1'b1;
            retrieve_rec_q <= rec_q;
        end else if (retrieve_done) begin
            retrieve_q <= 1'b0;
        end
    end
    assign retrieve_req = retrieve_q;
    assign retrieve_record = retrieve_rec_q;
    // ********************************************************************
    // axis buffers and axis output registers
    // ********************************************************************
    logic loaded_q;
    logic [1:0] rt_axis_q;
    logic data_ready_q;
    logic [15:0] axis_out_q [VOR_NAXIS];
    // contents are valid once the first record or retrieval completes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loaded_q <= 1'b0;
        end else if (record_done || retrieve_done) begin
            loaded_q <= 1'b1;
        end
    end

    // real-time axis selection and data-ready pulse
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rt_axis_q <= 2'h0;
            data_ready_q <= 1'b0;
        end else begin
            if (axis_rd && realtime_mode) begin
                rt_axis_q <= axis_sel;
            end
            data_ready_q <= realtime_mode & rt_valid;
        end
    end
    assign data_ready = data_ready_q;
    genvar g;
    generate
        for (g = 0; g < VOR_NAXIS; g++) begin : g_axis
            logic [15:0] mem_q [VOR_DEPTH];
            // storage written only by the engines
            always_ff @(posedge clk) begin
                if (cap.wr) begin
                    mem_q[cap.addr] <= cap.data[g];
                end
            end

            // presented word follows the index or the real-time stream
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    axis_out_q[g] <= VOR_OUT_RST;
                end else if (realtime_mode) begin
                    if (rt_valid && rt_axis_q == 2'(g)) begin
                        axis_out_q[g] <= rt_sample;
                    end
                end else if (loaded_q) begin
                    axis_out_q[g] <= mem_q[idx_q];
                end
            end
        end
    endgenerate

    // ********************************************************************
    // supply and temperature averaging
    // ********************************************************************
    localparam int NCH = 2;
    localparam int PER [NCH] = '{SUPPLY_WIN_CYC / VOR_SUP_NSAMP,
                                 TEMP_WIN_CYC / VOR_TEMP_NSAMP};
    localparam int NSAMP [NCH] = '{VOR_SUP_NSAMP, VOR_TEMP_NSAMP};
    localparam int SHIFT [NCH] = '{VOR_SUP_SHIFT, VOR_TEMP_SHIFT};
    vor_meas_e meas_q;
    logic rt_mode_q;
    logic meas_go;
    logic [NCH-1:0] ch_valid;
    logic [VOR_RESULT_W-1:0] ch_code [NCH];
    logic [NCH-1:0] ch_done_q;
    logic [NCH-1:0] ch_start_q;
    logic [15:0] ch_res_q [NCH];
    // start at record end, or once at real-time entry only
    assign meas_go = (record_done & ~realtime_mode) |
                     (realtime_mode & ~rt_mode_q);
    assign ch_valid = {temp_valid, supply_valid};
    assign ch_code[0] = supply_code;
    assign ch_code[1] = temp_code;
    // previous real-time level for the entry edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rt_mode_q <= 1'b0;
        end else begin
            rt_mode_q <= realtime_mode;
        end
    end

    // measurement sequence: runs until both channels have averaged
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meas_q <= VOR_MEAS_IDLE;
        end else begin
            case (meas_q)
                VOR_MEAS_IDLE: begin
                    if (meas_go) begin
                        meas_q <= VOR_MEAS_RUN;
                    end
                end
                VOR_MEAS_RUN: begin
                    if (&ch_done_q && !meas_go) begin
                        meas_q <= VOR_MEAS_IDLE;
                    end
                end
                default: begin
                    meas_q <= VOR_MEAS_IDLE;
                end
            endcase
        end
    end
    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_meas
            logic [15:0] per_cnt_q;
            logic [8:0] issued_q;
            logic [8:0] got_q;
            logic [19:0] acc_q;
            // paced conversion starts and accumulation of the codes
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    per_cnt_q <= 16'h0000;
                    issued_q <= 9'h000;
                    got_q <= 9'h000;
                    acc_q <= 20'h00000;
                    ch_done_q[c] <= 1'b1;
                    ch_start_q[c] <= 1'b0;
                    ch_res_q[c] <= VOR_OUT_RST;
                end else if (meas_go) begin
                    per_cnt_q <= 16'h0000;
                    issued_q <= 9'h000;
                    got_q <= 9'h000;
                    acc_q <= 20'h00000;
                    ch_done_q[c] <= 1'b0;
                    ch_start_q[c] <= 1'b0;
                end else if (meas_q == VOR_MEAS_RUN && !ch_done_q[c]) begin
                    // pace at the sample period
                    if (per_cnt_q == 16'(PER[c] - 1)) begin
                        per_cnt_q <= 16'h0000;
                    end else begin
                        per_cnt_q <= per_cnt_q + 16'h0001;
                    end
                    ch_start_q[c] <= (per_cnt_q == 16'h0000) &&
                                     (issued_q != 9'(NSAMP[c]));
                    if (per_cnt_q == 16'h0000 &&
                        issued_q != 9'(NSAMP[c])) begin
                        issued_q <= issued_q + 9'h001;
                    end
                    if (ch_valid[c]) begin
                        acc_q <= acc_q + 20'(ch_code[c]);
                        got_q <= got_q + 9'h001;
                        if (got_q == 9'(NSAMP[c] - 1)) begin
                            ch_done_q[c] <= 1'b1;
                            // average, upper bits zero
                            ch_res_q[c] <= {4'h0, VOR_RESULT_W'(
                                (acc_q + 20'(ch_code[c])) >> SHIFT[c])};
                        end
                    end
                end else begin
                    ch_start_q[c] <= 1'b0;
                end
            end
        end
    endgenerate
    assign supply_start = ch_start_q[0];
    assign temp_start = ch_start_q[1];
    // ********************************************************************
    // read answer, shifted out in the following frame
    // ********************************************************************
    // answer latched at a read frame, cleared by a write frame
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            resp_q <= 16'h0000;
        end else if (rd_evt) begin
            case (rx_word_q.addr)
                VOR_ADDR_TEMP: resp_q <= ch_res_q[1];
                VOR_ADDR_SUPPLY: resp_q <= ch_res_q[0];
                VOR_ADDR_IDX_LO: resp_q <= {7'h00, idx_q};
                VOR_ADDR_REC_LO: resp_q <= {12'h000, rec_q};
                VOR_ADDR_X, VOR_ADDR_Y, VOR_ADDR_Z: begin
                    resp_q <= axis_out_q[axis_sel];
                end
                default: resp_q <= 16'h0000;
            endcase
        end else if (wr_evt) begin
            resp_q <= 16'h0000;
        end
    end
endmodule : vor_readout

// ===== vor_readout_assertions.sv
// vor_readout_assertions: port-level timing checks of the readout block
module vor_readout_assertions
    import vor_pkg::*;
#(
    parameter int SUPPLY_WIN_CYC = VOR_SUP_WIN_CYC,
    parameter int TEMP_WIN_CYC = VOR_TEMP_WIN_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // capture and stored record engines
    input wire logic record_done,
    input wire logic realtime_mode,
    input wire logic rt_valid,
    input wire logic data_ready,
    input wire logic retrieve_req,
    input wire logic [VOR_REC_W-1:0] retrieve_record,
    input wire logic retrieve_done,
    // converters
    input wire logic supply_start,
    input wire logic temp_start
);
    // ****************************************************************
    // all checks run on clk and pause during reset
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_rdy_follow;
        realtime_mode && rt_valid |=> data_ready;
    endproperty
    a_rdy_follow: assert property (p_rdy_follow)
        else $error("data_ready missing after rt_valid");
    property p_rdy_cause;
        data_ready |-> $past(rt_valid) && $past(realtime_mode);
    endproperty
    a_rdy_cause: assert property (p_rdy_cause)
        else $error("data_ready without a real-time sample");
    property p_sup_rec;
        record_done && !realtime_mode |-> ##[1:4] supply_start;
    endproperty
    a_sup_rec: assert property (p_sup_rec)
        else $error("supply run not started at record end");
    property p_tmp_rec;
        record_done && !realtime_mode |-> ##[1:4] temp_start;
    endproperty
    a_tmp_rec: assert property (p_tmp_rec)
        else $error("temperature run not started at record end");
    property p_sup_rt;
        $rose(realtime_mode) |-> ##[1:4] supply_start;
    endproperty
    a_sup_rt: assert property (p_sup_rt)
        else $error("supply run not started with real-time mode");
    property p_sup_gap;
        supply_start |=> !supply_start [*8];
    endproperty
    a_sup_gap: assert property (p_sup_gap)
        else $error("supply conversions started too close");
    property p_tmp_gap;
        temp_start |=> !temp_start [*8];
    endproperty
    a_tmp_gap: assert property (p_tmp_gap)
        else $error("temperature conversions started too close");
    property p_ret_hold;
        retrieve_req && !retrieve_done |=> retrieve_req
            && $stable(retrieve_record);
    endproperty
    a_ret_hold: assert property (p_ret_hold)
        else $error("retrieve request dropped or changed early");
    property p_ret_end;
        retrieve_req && retrieve_done |=> !retrieve_req;
    endproperty
    a_ret_end: assert property (p_ret_end)
        else $error("retrieve request not cleared when done");
endmodule : vor_readout_assertions

bind vor_readout vor_readout_assertions #(
    .SUPPLY_WIN_CYC(SUPPLY_WIN_CYC), .TEMP_WIN_CYC(TEMP_WIN_CYC)
) u_chk (
    .clk(clk), .nrst(nrst), .record_done(record_done),
    .realtime_mode(realtime_mode), .rt_valid(rt_valid),
    .data_ready(data_ready), .retrieve_req(retrieve_req),
    .retrieve_record(retrieve_record), .retrieve_done(retrieve_done),
    .supply_start(supply_start), .temp_start(temp_start)
);

// ===== vor_host.sv
// vor_host: serial host model sending 16-bit register frames
module vor_host (
    // serial port toward the block
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic dout
);
    timeunit 1ns;
    timeprecision 1ps;

    // sclk stands high between frames
    initial begin
        sclk = 1'b1;
        din = 1'b0;
        #1 cs_n = 1'b1;  // a real rising edge clears the bit counter
    end

    // one frame, MSB first: drive on sclk fall, sample on rise
    task automatic xfer(input logic [15:0] w, output logic [15:0] r);
        #7 cs_n = 1'b0;
        #80;
        for (int i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            din = w[i];
            #80 sclk = 1'b1;
            r[i] = dout;
            #80;
        end
        cs_n = 1'b1;
        din = ~din;  // released line shows no stale value
        #400;        // gap lets the answer settle
    endtask : xfer
endmodule : vor_host

// ===== testbench.sv
// testbench: register-level tests of the vibration output readout
module testbench
    import vor_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // stimulus and observed signals
    // ****************************************************************
    logic clk = 1'b0;
    logic nrst = 1'b1;
    wire logic sclk, cs_n, din, dout;
    vor_capture_s cap = '0;
    logic record_done = 1'b0, realtime_mode = 1'b0, rt_valid = 1'b0;
    logic retrieve_done = 1'b0, supply_valid = 1'b0, temp_valid = 1'b0;
    logic [15:0] rt_sample = 16'h0000;
    logic [11:0] supply_code = 12'hA8F, temp_code = 12'h4FE;
    logic data_ready, retrieve_req, supply_start, temp_start;
    logic [3:0] retrieve_record;
    logic [15:0] rdat;
    int fail_count = 0, tests_run = 0;

    always #20 clk = ~clk;

    // converter stand-ins answer each start one cycle later
    always @(negedge clk) begin
        supply_valid <= supply_start;
        temp_valid <= temp_start;
    end

    vor_readout #(.SUPPLY_WIN_CYC(2560), .TEMP_WIN_CYC(640)) dut (
        .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .cap(cap), .record_done(record_done),
        .realtime_mode(realtime_mode), .rt_valid(rt_valid),
        .rt_sample(rt_sample), .data_ready(data_ready),
        .retrieve_req(retrieve_req), .retrieve_record(retrieve_record),
        .retrieve_done(retrieve_done), .supply_start(supply_start),
        .supply_valid(supply_valid), .supply_code(supply_code),
        .temp_start(temp_start), .temp_valid(temp_valid),
        .temp_code(temp_code)
    );
    vor_host host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic conclude;
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [15:0] r;
        host.xfer({1'b1, a, d}, r);
    endtask : wr

    // read frame, then a harmless temperature read fetches the answer
    task automatic rd(input logic [6:0] a, input logic [15:0] e,
                      input string n);
        logic [15:0] r;
        host.xfer({1'b0, a, 8'h00}, r);
        host.xfer({1'b0, VOR_ADDR_TEMP, 8'h00}, r);
        chk(n, e, r);
    endtask : rd

    // distinct pattern per axis and position
    function automatic logic [15:0] pat(input logic [1:0] a,
                                        input logic [8:0] i,
                                        input logic [15:0] b);
        return b + {2'h0, a, 12'h000} + {7'h00, i};
    endfunction : pat

    // engine stand-in: write a whole record into the axis buffers
    task automatic fill(input logic [15:0] b);
        for (int i = 0; i < VOR_DEPTH; i++) begin
            @(negedge clk);
            cap.wr = 1'b1;
            cap.addr = i[8:0];
            for (int k = 0; k < 3; k++) cap.data[k] = pat(k[1:0], i[8:0], b);
        end
        @(negedge clk);
        cap = '0;
    endtask : fill

    task automatic wait_req;
        int n;
        for (n = 0; n < 200 && retrieve_req !== 1'b1; n++) @(negedge clk);
        if (n == 200) begin
            fail_count++;
            conclude();
        end
    endtask : wait_req

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        @(negedge clk) nrst = 1'b0;  // a real edge resets the link flops
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        rd(VOR_ADDR_IDX_LO, 16'h0000, "index reset");
        rd(VOR_ADDR_X, VOR_OUT_RST, "x reset");
        rd(VOR_ADDR_SUPPLY, VOR_OUT_RST, "supply reset");
        rd(VOR_ADDR_TEMP, VOR_OUT_RST, "temp reset");
        fill(16'h0000);
        @(negedge clk) record_done = 1'b1;
        @(negedge clk) record_done = 1'b0;
        repeat (2700) @(negedge clk);  // supply window is 2560 cycles
        rd(VOR_ADDR_X, pat(0, 0, 0), "x first");
        rd(VOR_ADDR_Y, pat(1, 1, 0), "y next");
        rd(VOR_ADDR_Z, pat(2, 2, 0), "z next");
        rd(VOR_ADDR_SUPPLY, 16'h0A8F, "supply avg");
        rd(VOR_ADDR_TEMP, 16'h04FE, "temp avg");
        wr(VOR_ADDR_IDX_HI, 8'h00);
        wr(VOR_ADDR_IDX_LO, 8'h9F);
        rd(VOR_ADDR_IDX_LO, 16'h009F, "index");
        rd(VOR_ADDR_X, pat(0, 9'h09F, 0), "x at index");
        rd(VOR_ADDR_Y, pat(1, 9'h0A0, 0), "y after");
        wr(VOR_ADDR_IDX_HI, 8'hFF);
        wr(VOR_ADDR_IDX_LO, 8'hFF);
        rd(VOR_ADDR_IDX_LO, 16'h01FF, "index top");
        rd(VOR_ADDR_Z, pat(2, 9'h1FF, 0), "z last");
        rd(VOR_ADDR_IDX_LO, 16'h0000, "index wrap");
        wr(VOR_ADDR_TEMP, 8'h12);
        rd(VOR_ADDR_TEMP, 16'h04FE, "temp ro");
        rd(7'h30, 16'h0000, "unmapped");
        wr(VOR_ADDR_IDX_LO, 8'h20);
        wr(VOR_ADDR_CMD_HI, 8'h04);
        rd(VOR_ADDR_IDX_LO, 16'h0000, "index clear");
        wr(VOR_ADDR_REC_LO, 8'h0A);
        rd(VOR_ADDR_REC_LO, 16'h000A, "record index");
        wr(VOR_ADDR_CMD_HI, 8'h20);
        wait_req();
        chk("record", 16'h000A, {12'h000, retrieve_record});
        fill(16'h4000);
        @(negedge clk) retrieve_done = 1'b1;
        @(negedge clk) retrieve_done = 1'b0;
        repeat (2) @(negedge clk);
        chk("retrieve_req", 16'h0000, {15'h0, retrieve_req});
        rd(VOR_ADDR_X, pat(0, 0, 16'h4000), "x stored");
        @(negedge clk) realtime_mode = 1'b1;
        host.xfer({1'b0, VOR_ADDR_Y, 8'h00}, rdat);
        for (int s = 0; s < 2; s++) begin
            repeat (20) @(negedge clk);
            rt_sample = (s == 0) ? 16'h8000 : 16'h7FFF;
            rt_valid = 1'b1;
            @(negedge clk) rt_valid = 1'b0;
            chk("data_ready", 16'h0001, {15'h0, data_ready});
            rd(VOR_ADDR_Y, rt_sample, "rt sample");
        end
        conclude();
    end
endmodule : testbench
